// ==== core/pic_pkg.sv ====
// Constants, register map and types of the prioritized interrupt controller
// Function
// RL1: Positions 0-3: wake timer, pin A, pin B, watchdog
// RL2: Positions 4-7: timer, ADC, flash, SPI
// RL3: Positions 8-10: LIN frame, error, sleep/wake
// RL4: 11 HV, 12 osc cal, 13 ECC, 14-16 unused
// RL5: Only 0,1,2,3,10 wake from hibernate
// RL6: Any permitted wake returns to active mode
// RL7: Priority 0 most urgent, 7 least
// RL8: All priority fields reset to zero
// RL9: Level zero ranks below reset, NMI, fault
// RL10: Equal levels: lowest position wins
// RL11: Per-interrupt enable via set/clear registers
// RL12: Each priority register holds four fields
// RL13: Group zero bits 31:29 is position 3
// RL14: Group zero bits 23:21 is position 2
// RL15: Group zero bits 15:13 is position 1
// RL16: Group zero bits 7:5 is position 0
// RL17: Field 000 most urgent, 111 least
// RL18: Later groups same layout, next four positions
// RL19: Low five bits per lane read zero
// RL20: Write one sets/clears enable, zero ignored
// RL21: Disabled interrupts still pend, never activate
// RL22: Present most urgent enabled pending vector
package pic_pkg;
  localparam int unsigned NUM_IRQ = 17;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned FIELD_LSB = 5;
  localparam int unsigned PRIO_PER_REG = 4;
  localparam int unsigned PRIO_REGS = 5;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SET_EN = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_CLR_EN = 12'h180;
  localparam logic [ADDR_W-1:0] OFF_SET_PEND = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_CLR_PEND = 12'h280;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE = 12'h300;
  localparam logic [ADDR_W-1:0] OFF_PRIO_BASE = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h500;
  // Status register fields
  localparam int unsigned STAT_REQ_BIT = 8;
  localparam int unsigned STAT_PWR_LSB = 16;
  // Priority values
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic [3:0] SYS_RANKS = 4'h3;
  localparam logic [3:0] IDLE_LEVEL = 4'h8;
  // Source positions
  localparam int unsigned IRQ_WAKE_TIMER = 0;
  localparam int unsigned IRQ_EXT_PIN_A = 1;
  localparam int unsigned IRQ_EXT_PIN_B = 2;
  localparam int unsigned IRQ_WATCHDOG = 3;
  localparam int unsigned IRQ_GP_TIMER = 4; // [RL2]
  localparam int unsigned IRQ_ADC = 5;
  localparam int unsigned IRQ_FLASH = 6;
  localparam int unsigned IRQ_SPI = 7;
  localparam int unsigned IRQ_LIN_FRAME = 8;
  localparam int unsigned IRQ_LIN_ERROR = 9;
  localparam int unsigned IRQ_LIN_WAKE = 10;
  localparam int unsigned IRQ_HV_IF = 11; // [RL4]
  localparam int unsigned IRQ_OSC_CAL = 12;
  localparam int unsigned IRQ_SRAM_ECC = 13;
  localparam int unsigned IRQ_UNUSED_A = 14;
  // Sources allowed to leave hibernate
  localparam logic [NUM_IRQ-1:0] WAKE_MASK = NUM_IRQ'((1 << IRQ_WAKE_TIMER)
    | (1 << IRQ_EXT_PIN_A) | (1 << IRQ_EXT_PIN_B) | (1 << IRQ_WATCHDOG)
    | (1 << IRQ_LIN_WAKE)); // [RL1] [RL3] [RL5]
  // Power mode states
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_HIBERNATE = 3'b100
  } pic_pwr_t;
endpackage

// ==== core/pic_arb_if.sv ====
// Arbitration request and result between controller and arbiter
`timescale 1ns/100ps
interface pic_arb_if #(
  parameter int unsigned N = 17
);
  logic [N-1:0] cand;
  logic [N*3-1:0] prio;
  logic found;
  logic [4:0] idx;
  logic [2:0] level;
  modport arb (input cand, input prio, output found, output idx, output level);
  modport ctl (output cand, output prio, input found, input idx, input level);
endinterface // pic_arb_if

// ==== core/pic_arbiter.sv ====
// Priority arbiter: most urgent level, lowest position on ties
`timescale 1ns/100ps
module pic_arbiter #(
  parameter int unsigned N = 17
) (
  // Candidates and winner
  pic_arb_if.arb arb
);
  // Refuse sizes the five-bit index cannot name
  if (N < 1 || N > 32) begin : g_bad_n
    $error("pic_arbiter: N out of range");
  end

  // Scan upward, strict compare keeps lowest position on a tie
  always_comb begin
    arb.found = 1'b0;
    arb.idx = '0;
    arb.level = '1;
    for (int i = 0; i < N; i++) begin
      if (arb.cand[i] && (!arb.found || arb.prio[i*3 +: 3] < arb.level)) begin // [RL7] [RL10]
        arb.found = 1'b1;
        arb.idx = 5'(i);
        arb.level = arb.prio[i*3 +: 3];
      end
    end
  end
endmodule // pic_arbiter

// ==== core/pic_top.sv ====
// Prioritized vectored interrupt controller with APB registers
`timescale 1ns/100ps
module pic_top #(
  parameter int unsigned NUM_IRQ = pic_pkg::NUM_IRQ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pic_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral interrupt lines
  input wire logic [NUM_IRQ-1:0] irq_lines,
  // Core request side
  output logic irq_req,
  output logic [pic_pkg::IDX_W-1:0] irq_vector,
  output logic [3:0] irq_rank,
  input wire logic irq_ack,
  input wire logic irq_exit,
  input wire logic [pic_pkg::IDX_W-1:0] exit_vector,
  // Power mode
  input wire logic sleep_req,
  input wire logic deep_sleep,
  output logic pwr_active,
  output logic pwr_hibernate,
  output logic wake_pulse
);
  localparam int unsigned PW = pic_pkg::PRIO_W;

  // Refuse sizes the map and vector cannot hold
  if (NUM_IRQ < 1 || NUM_IRQ > 2 ** pic_pkg::IDX_W
      || NUM_IRQ > pic_pkg::PRIO_REGS * pic_pkg::PRIO_PER_REG) begin : g_bad_size
    $error("pic_top: NUM_IRQ out of range");
  end

  // Register index of an address inside the priority block
  function automatic logic [pic_pkg::ADDR_W-1:0] prio_index(
    input logic [pic_pkg::ADDR_W-1:0] a);
    prio_index = (a - pic_pkg::OFF_PRIO_BASE) >> 2;
  endfunction

  // True for an address inside the priority block
  function automatic logic is_prio(input logic [pic_pkg::ADDR_W-1:0] a);
    is_prio = (a >= pic_pkg::OFF_PRIO_BASE) && (a[1:0] == 2'b00)
      && (prio_index(a) < pic_pkg::ADDR_W'(pic_pkg::PRIO_REGS));
  endfunction

  // True for any mapped word address
  function automatic logic is_mapped(input logic [pic_pkg::ADDR_W-1:0] a);
    is_mapped = (a == pic_pkg::OFF_SET_EN) || (a == pic_pkg::OFF_CLR_EN)
      || (a == pic_pkg::OFF_SET_PEND) || (a == pic_pkg::OFF_CLR_PEND)
      || (a == pic_pkg::OFF_ACTIVE) || (a == pic_pkg::OFF_STATUS) || is_prio(a);
  endfunction

  // Write-one mask from the data word for the given offset
  function automatic logic [NUM_IRQ-1:0] w1_mask(
    input logic [pic_pkg::ADDR_W-1:0] a,
    input logic [pic_pkg::ADDR_W-1:0] off,
    input logic [31:0] d);
    w1_mask = (a == off) ? d[NUM_IRQ-1:0] : '0;
  endfunction

  logic [NUM_IRQ-1:0] en_q;
  logic [NUM_IRQ-1:0] pend_q;
  logic [NUM_IRQ-1:0] act_q;
  logic [PW-1:0] prio_q [NUM_IRQ];
  logic [31:0] prdata_q;
  logic irq_req_q;
  logic [pic_pkg::IDX_W-1:0] irq_vector_q;
  logic [3:0] irq_rank_q;
  logic wake_pulse_q;
  pic_pkg::pic_pwr_t pwr_q;
  pic_pkg::pic_pwr_t pwr_d;
  logic wr_en;
  logic rd_setup;
  logic [NUM_IRQ-1:0] set_en;
  logic [NUM_IRQ-1:0] clr_en;
  logic [NUM_IRQ-1:0] set_pend;
  logic [NUM_IRQ-1:0] clr_pend;
  logic [NUM_IRQ-1:0] ack_hot;
  logic [NUM_IRQ-1:0] exit_hot;
  logic [NUM_IRQ-1:0] hw_set;
  logic [NUM_IRQ-1:0] cand;
  logic [3:0] run_level;
  logic better;
  logic [31:0] rd_word;

  pic_arb_if #(.N(NUM_IRQ)) arb_bus ();

  // Winner search over enabled pending sources
  pic_arbiter #(.N(NUM_IRQ)) u_arb (
    .arb(arb_bus.arb)
  );

  // APB handshake: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign wr_en = psel && penable && pwrite && is_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;

  // Write-one strobes, zeros have no effect
  assign set_en = wr_en ? w1_mask(paddr, pic_pkg::OFF_SET_EN, pwdata) : '0; // [RL11] [RL20]
  assign clr_en = wr_en ? w1_mask(paddr, pic_pkg::OFF_CLR_EN, pwdata) : '0; // [RL11] [RL20]
  assign set_pend = wr_en ? w1_mask(paddr, pic_pkg::OFF_SET_PEND, pwdata) : '0;
  assign clr_pend = wr_en ? w1_mask(paddr, pic_pkg::OFF_CLR_PEND, pwdata) : '0;

  // One-hot forms of the acknowledged and returning vectors
  always_comb begin
    ack_hot = '0;
    exit_hot = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      ack_hot[i] = irq_ack && irq_req_q && (irq_vector_q == pic_pkg::IDX_W'(i));
      exit_hot[i] = irq_exit && (exit_vector == pic_pkg::IDX_W'(i));
    end
  end

  // Asserted lines pend whether enabled or not, unless already active
  assign hw_set = irq_lines & ~act_q; // [RL21]

  // Enable bits: set wins when both hit the same bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
    end else begin
      en_q <= (en_q & ~clr_en) | set_en; // [RL20]
    end
  end

  // Pending flags: software sets win over all clears, hardware sets win over software clears but not over acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~clr_pend & ~ack_hot) | set_pend | (hw_set & ~ack_hot); // [RL21]
    end
  end

  // Active flags: set on acknowledge, cleared on exception return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= '0;
    end else begin
      act_q <= (act_q & ~exit_hot) | ack_hot;
    end
  end

  // Priority fields, byte lane n holds position 4r+n in its top bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio_q[i] <= pic_pkg::PRIO_RESET; // [RL8]
      end
    end else if (wr_en && is_prio(paddr)) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (prio_index(paddr) == pic_pkg::ADDR_W'(i / pic_pkg::PRIO_PER_REG)
            && pstrb[i % pic_pkg::PRIO_PER_REG]) begin // [RL12] [RL18]
          prio_q[i] <= pwdata[(i % pic_pkg::PRIO_PER_REG) * pic_pkg::LANE_W
                              + pic_pkg::FIELD_LSB +: PW]; // [RL13] [RL14] [RL15] [RL16]
        end
      end
    end
  end

  // Read mux, reserved bits and unused lanes read zero
  always_comb begin
    rd_word = '0;
    if (paddr == pic_pkg::OFF_SET_EN || paddr == pic_pkg::OFF_CLR_EN) begin
      rd_word[NUM_IRQ-1:0] = en_q;
    end else if (paddr == pic_pkg::OFF_SET_PEND || paddr == pic_pkg::OFF_CLR_PEND) begin
      rd_word[NUM_IRQ-1:0] = pend_q; // [RL21]
    end else if (paddr == pic_pkg::OFF_ACTIVE) begin
      rd_word[NUM_IRQ-1:0] = act_q;
    end else if (paddr == pic_pkg::OFF_STATUS) begin
      rd_word[pic_pkg::IDX_W-1:0] = irq_vector_q;
      rd_word[pic_pkg::STAT_REQ_BIT] = irq_req_q;
      rd_word[pic_pkg::STAT_PWR_LSB +: 3] = pwr_q;
    end else if (is_prio(paddr)) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (prio_index(paddr) == pic_pkg::ADDR_W'(i / pic_pkg::PRIO_PER_REG)) begin
          rd_word[(i % pic_pkg::PRIO_PER_REG) * pic_pkg::LANE_W
                  + pic_pkg::FIELD_LSB +: PW] = prio_q[i]; // [RL19]
        end
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= rd_word;
    end
  end
  assign prdata = prdata_q;

  // Only enabled pending sources compete
  assign cand = pend_q & en_q; // [RL21]
  assign arb_bus.cand = cand;
  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      arb_bus.prio[i*PW +: PW] = prio_q[i]; // [RL17]
    end
  end

  // Level of the most urgent active handler, idle when none
  always_comb begin
    run_level = pic_pkg::IDLE_LEVEL;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (act_q[i] && {1'b0, prio_q[i]} < run_level) begin
        run_level = {1'b0, prio_q[i]};
      end
    end
  end

  // Winner must preempt the running level
  assign better = arb_bus.found && ({1'b0, arb_bus.level} < run_level);

  // Registered request to the core, dropped for one cycle after acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= 1'b0;
      irq_vector_q <= '0;
      irq_rank_q <= '0;
    end else begin
      irq_req_q <= better && !irq_ack; // [RL22]
      irq_vector_q <= arb_bus.idx; // [RL22]
      irq_rank_q <= pic_pkg::SYS_RANKS + {1'b0, arb_bus.level}; // [RL9]
    end
  end
  assign irq_req = irq_req_q;
  assign irq_vector = irq_vector_q;
  assign irq_rank = irq_rank_q;

  // Power mode transitions
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      pic_pkg::PWR_ACTIVE: begin
        if (sleep_req) begin
          pwr_d = deep_sleep ? pic_pkg::PWR_HIBERNATE : pic_pkg::PWR_SLEEP;
        end
      end
      pic_pkg::PWR_SLEEP: begin
        if (|cand) begin
          pwr_d = pic_pkg::PWR_ACTIVE; // [RL6]
        end
      end
      pic_pkg::PWR_HIBERNATE: begin
        if (|(cand & pic_pkg::WAKE_MASK)) begin // [RL5]
          pwr_d = pic_pkg::PWR_ACTIVE; // [RL6]
        end
      end
      default: begin
        pwr_d = pic_pkg::PWR_ACTIVE;
      end
    endcase
  end

  // Power state and wake pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= pic_pkg::PWR_ACTIVE;
      wake_pulse_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      wake_pulse_q <= (pwr_q != pic_pkg::PWR_ACTIVE) && (pwr_d == pic_pkg::PWR_ACTIVE);
    end
  end
  assign pwr_active = (pwr_q == pic_pkg::PWR_ACTIVE);
  assign pwr_hibernate = (pwr_q == pic_pkg::PWR_HIBERNATE);
  assign wake_pulse = wake_pulse_q;
endmodule // pic_top

// ==== dv/pic_asserts.sv ====
// Port-level checks of the interrupt controller
`timescale 1ns/100ps
module pic_asserts #(
  parameter int unsigned NUM_IRQ = 17
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Core side and power
  input wire logic irq_req,
  input wire logic [pic_pkg::IDX_W-1:0] irq_vector,
  input wire logic [3:0] irq_rank,
  input wire logic irq_ack,
  input wire logic sleep_req,
  input wire logic deep_sleep,
  input wire logic pwr_active,
  input wire logic pwr_hibernate,
  input wire logic wake_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Steps of a handshake and a mode entry
  sequence s_taken;
    irq_ack && irq_req;
  endsequence
  sequence s_enter_hib;
    pwr_active && sleep_req && deep_sleep;
  endsequence
  a_ack_drops_req: assert property (s_taken |=> !irq_req)
    else $error("request stayed after ack");
  a_rank_above_sys: assert property (irq_req |-> irq_rank inside {[4'h3:4'ha]})
    else $error("rank outside programmable range");
  a_vector_in_range: assert property (irq_req |-> irq_vector < NUM_IRQ)
    else $error("vector beyond last position");
  a_ready_always: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_hib_entry: assert property (s_enter_hib |=> pwr_hibernate && !pwr_active)
    else $error("hibernate not entered");
  a_wake_follows: assert property ($rose(pwr_active) |-> ##[0:1] wake_pulse)
    else $error("no wake pulse on return to active");
  a_wake_single: assert property (wake_pulse |-> pwr_active ##1 !wake_pulse)
    else $error("wake pulse too long");
  a_mode_exclusive: assert property (!(pwr_active && pwr_hibernate))
    else $error("two power modes at once");
endmodule // pic_asserts

// ==== dv/pic_core_model.sv ====
// Processor core model: takes presented vectors and returns from handlers
`timescale 1ns/100ps
module pic_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from bench
  input wire logic en,
  // Controller side
  input wire logic irq_req,
  input wire logic [pic_pkg::IDX_W-1:0] irq_vector,
  output logic irq_ack,
  output logic irq_exit,
  output logic [pic_pkg::IDX_W-1:0] exit_vector,
  // Observation
  output logic [pic_pkg::IDX_W-1:0] last_vec,
  output logic [7:0] n_ack
);
  logic [2:0] cnt_q;
  // Ack, short handler, exception return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      irq_exit <= 1'b0;
      cnt_q <= 3'h0;
      last_vec <= 5'h00;
      n_ack <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      irq_exit <= 1'b0;
      if (irq_ack && irq_req) begin
        last_vec <= irq_vector;
        n_ack <= n_ack + 8'h01;
        cnt_q <= 3'h4;
      end else if (cnt_q > 3'h1) begin
        cnt_q <= cnt_q - 3'h1;
      end else if (cnt_q == 3'h1) begin
        irq_exit <= 1'b1;
        cnt_q <= 3'h0;
      end else if (en && irq_req && !irq_ack && !irq_exit) begin
        irq_ack <= 1'b1;
      end
    end
  end
  // Vector valid only with the exit strobe
  assign exit_vector = irq_exit ? last_vec : ~last_vec;
endmodule // pic_core_model

// ==== dv/prioritized_interrupt_controller_test.sv ====
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
module prioritized_interrupt_controller_test;
  typedef struct packed {
    logic [16:0] lines;
    logic [31:0] p0;
    logic [31:0] p1;
    logic [4:0] vec;
    logic [3:0] rank;
  } pic_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, irq_rank;
  logic [16:0] irq_lines = 17'h0;
  logic irq_req, irq_ack, irq_exit, sleep_req = 1'b0, deep_sleep = 1'b0, en = 1'b0;
  logic pready, pslverr, pwr_active, pwr_hibernate, wake_pulse, er;
  logic [4:0] irq_vector, exit_vector, last_vec;
  logic [7:0] n_ack;
  int fail_count = 0, n_tests = 0;
  pic_row_t rows [6] = '{
    '{17'h00009, 32'h00000000, 32'h00000000, 5'h00, 4'h3},
    '{17'h0000a, 32'h0000a000, 32'h00000000, 5'h03, 4'h3},
    '{17'h00005, 32'h00c000e0, 32'h00000000, 5'h02, 4'h9},
    '{17'h000a0, 32'h00000000, 32'h20002000, 5'h05, 4'h4},
    '{17'h00050, 32'h00000000, 32'h00400080, 5'h06, 4'h5},
    '{17'h12000, 32'h00000000, 32'h00000000, 5'h0d, 4'h3}};
  pic_top i_pic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_lines(irq_lines), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_rank(irq_rank), .irq_ack(irq_ack), .irq_exit(irq_exit),
    .exit_vector(exit_vector), .sleep_req(sleep_req), .deep_sleep(deep_sleep),
    .pwr_active(pwr_active), .pwr_hibernate(pwr_hibernate), .wake_pulse(wake_pulse));
  pic_core_model i_pic_core_model (.pclk(pclk), .presetn(presetn), .en(en),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_exit(irq_exit),
    .exit_vector(exit_vector), .last_vec(last_vec), .n_ack(n_ack));
  // Clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Verdict and end of run
  task summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Compare a word
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, starting after an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Drive lines for one cycle
  task pulse(input logic [16:0] l);
    @(posedge pclk) irq_lines <= l;
    @(posedge pclk) irq_lines <= 17'h0;
  endtask
  // Wait for active mode, bounded
  task wait_active();
    int k;
    #1;
    for (k = 0; k < 20 && pwr_active !== 1'b1; k++) begin
      @(posedge pclk);
      #1;
    end
    if (k >= 20) begin
      fail_count++;
      summarize();
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'h400 + 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 12'h400, 32'hffffffff);
    apb(1'b0, 12'h400, 32'h0);
    chk(rd, 32'he0e0e0e0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h100, 32'h0001ffff);
    foreach (rows[i]) begin
      apb(1'b1, 12'h400, rows[i].p0);
      apb(1'b1, 12'h404, rows[i].p1);
      @(posedge pclk) irq_lines <= rows[i].lines;
      repeat (3) @(posedge pclk);
      #1;
      chk({26'h0, irq_req, irq_vector}, {27'h1, rows[i].vec});
      chk(32'(irq_rank), 32'(rows[i].rank));
      @(posedge pclk) irq_lines <= 17'h0;
      apb(1'b1, 12'h280, 32'h0001ffff);
    end
    apb(1'b1, 12'h180, 32'h00000200);
    apb(1'b1, 12'h100, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0001fdff);
    pulse(17'h00200);
    apb(1'b0, 12'h200, 32'h0);
    chk(rd, 32'h00000200);
    #1;
    chk({31'h0, irq_req}, 32'h0);
    apb(1'b1, 12'h280, 32'h00000200);
    en <= 1'b1;
    pulse(17'h00020);
    repeat (12) @(posedge pclk);
    chk({19'h0, n_ack, last_vec}, {19'h0, 8'h01, 5'h05});
    en <= 1'b0;
    @(posedge pclk) begin
      sleep_req <= 1'b1;
      deep_sleep <= 1'b1;
    end
    @(posedge pclk) sleep_req <= 1'b0;
    pulse(17'h00020);
    repeat (5) @(posedge pclk);
    chk({30'h0, pwr_active, pwr_hibernate}, 32'h1);
    apb(1'b1, 12'h280, 32'h00000020);
    pulse(17'h00400);
    wait_active();
    chk({30'h0, pwr_active, wake_pulse}, 32'h3);
    apb(1'b1, 12'h280, 32'h00000400);
    @(posedge pclk) begin
      sleep_req <= 1'b1;
      deep_sleep <= 1'b0;
    end
    @(posedge pclk) sleep_req <= 1'b0;
    #1;
    chk({30'h0, pwr_active, pwr_hibernate}, 32'h0);
    pulse(17'h00010);
    wait_active();
    chk({30'h0, pwr_active, wake_pulse}, 32'h3);
    // Reset in mid-run restores defaults
    apb(1'b1, 12'h404, 32'he0e0e0e0);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({29'h0, irq_req, pwr_active, wake_pulse}, 32'h2);
    @(posedge pclk) presetn <= 1'b1;
    apb(1'b0, 12'h404, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule // prioritized_interrupt_controller_test
bind pic_top pic_asserts #(.NUM_IRQ(NUM_IRQ)) i_pic_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_rank(irq_rank), .irq_ack(irq_ack), .sleep_req(sleep_req),
  .deep_sleep(deep_sleep), .pwr_active(pwr_active), .pwr_hibernate(pwr_hibernate),
  .wake_pulse(wake_pulse));
